/* hdl/pgc_top.sv */
// Pattern generator and checker, capture, acquisition trigger and output buffer control
`timescale 1ns/1ps
`default_nettype none

module pgc_fifo #(
   parameter int W = 1,
   parameter int D = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] wr_ptr;
      logic [AW-1:0] rd_ptr;
      logic [AW:0] count;
   } pgc_fifo_state_type;

   pgc_fifo_state_type st_ff, nxt_st;
   logic push, pop;

   assign in_ready = (st_ff.count != (AW+1)'(D));
   assign out_valid = (st_ff.count != '0);
   assign out_data = st_ff.mem[st_ff.rd_ptr];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_comb begin
      nxt_st = st_ff;
      if (push) begin
         nxt_st.mem[st_ff.wr_ptr] = in_data;
         nxt_st.wr_ptr = (st_ff.wr_ptr == AW'(D-1)) ? '0 : st_ff.wr_ptr + 1'b1;
      end
      if (pop) begin
         nxt_st.rd_ptr = (st_ff.rd_ptr == AW'(D-1)) ? '0 : st_ff.rd_ptr + 1'b1;
      end
      if (push && !pop) begin
         nxt_st.count = st_ff.count + 1'b1;
      end else if (pop && !push) begin
         nxt_st.count = st_ff.count - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_ff <= '0;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end
endmodule

module pgc_top (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire pgc_pkg::pgc_reg_req_type reg_req,
   output logic [7:0] reg_rdata,
   input wire logic rx_data_in,
   input wire pgc_pkg::pgc_rate_type rate_in,
   input wire logic out_ready,
   output logic acq_start_pulse,
   output pgc_pkg::pgc_pins_type pins
);
   import pgc_pkg::*;

   typedef enum logic [2:0] {
      CAP_IDLE = 3'b001,
      CAP_RUN = 3'b010,
      CAP_DONE = 3'b100
   } pgc_cap_state_type;

   typedef struct packed {
      logic [7:0] ctrl_b;
      logic [7:0] out_buf;
      logic [7:0] gen_ctrl;
      logic [7:0] run_len;
      logic [31:0] user_pattern;
      logic [7:0] chk_ctrl;
      logic rx_meta;
      logic rx_sync;
      pgc_rate_type rate_meta;
      pgc_rate_type rate_sync;
      logic [30:0] lfsr;
      logic [4:0] pat_idx;
      logic [10:0] seg_cnt;
      logic in_run;
      logic [30:0] chk_hist;
      logic pattern_error_flag;
      logic [7:0] pattern_error_tally;
      pgc_cap_state_type cap_state;
      logic [4:0] cap_cnt;
      logic [15:0] captured_sample;
      logic [7:0] rdata;
      logic acq_pulse;
      pgc_pins_type pins;
   } pgc_state_type;

   pgc_state_type st_ff, nxt_st;
   logic fifo_in_ready, fifo_out_valid, fifo_pop;
   logic src_bit, fifo_out_bit;

   // Feedback bit of the selected polynomial over a left-shifting history
   function automatic logic prbs_feedback(input logic [1:0] mode, input logic [30:0] s);
      case (mode)
         MODE_PRBS7: prbs_feedback = s[6] ^ s[5];
         MODE_PRBS15: prbs_feedback = s[14] ^ s[13];
         MODE_PRBS31: prbs_feedback = s[30] ^ s[27];
         default: prbs_feedback = 1'b0;
      endcase
   endfunction

   // Taps of the selected polynomial see only zeros, so a mode change could lock the output low
   function automatic logic prbs_stuck(input logic [1:0] mode, input logic [30:0] s);
      case (mode)
         MODE_PRBS7: prbs_stuck = (s[6:0] == 7'h00);
         MODE_PRBS15: prbs_stuck = (s[14:0] == 15'h0000);
         MODE_PRBS31: prbs_stuck = (s == 31'h00000000);
         default: prbs_stuck = 1'b0;
      endcase
   endfunction

   // Falling edge of a control bit caused by a register write
   function automatic logic write_falls(input logic [7:0] old_val, input logic [7:0] new_val,
                                        input int pos);
      write_falls = old_val[pos] & ~new_val[pos];
   endfunction

   function automatic logic [7:0] read_map(input pgc_state_type s, input logic [7:0] addr);
      case (addr)
         ADDR_RATE_FINE: read_map = s.rate_sync.osc_code[7:0];
         ADDR_RATE_CORE: read_map = {1'b0, s.rate_sync.full_rate,
                                     s.rate_sync.divide_rate, s.rate_sync.osc_code[9:8]};
         ADDR_CTRL_B: read_map = s.ctrl_b;
         ADDR_OUT_BUF: read_map = s.out_buf;
         ADDR_GEN_CTRL: read_map = s.gen_ctrl;
         ADDR_RUN_LEN: read_map = s.run_len;
         ADDR_PAT_B3: read_map = s.user_pattern[31:24];
         ADDR_PAT_B2: read_map = s.user_pattern[23:16];
         ADDR_PAT_B1: read_map = s.user_pattern[15:8];
         ADDR_PAT_B0: read_map = s.user_pattern[7:0];
         ADDR_CHK_CTRL: read_map = s.chk_ctrl;
         ADDR_ERR_CNT: read_map = s.pattern_error_tally;
         ADDR_ERR_STAT: read_map = {7'h00, s.pattern_error_flag};
         ADDR_CAP_HI: read_map = s.captured_sample[15:8];
         ADDR_CAP_LO: read_map = s.captured_sample[7:0];
         default: read_map = 8'h00;
      endcase
   endfunction

   pgc_fifo #(
      .W(FIFO_WIDTH),
      .D(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .in_valid(1'b1),
      .in_ready(fifo_in_ready),
      .in_data(src_bit),
      .out_valid(fifo_out_valid),
      .out_ready(out_ready),
      .out_data(fifo_out_bit)
   );

   assign fifo_pop = fifo_out_valid & out_ready;
   assign reg_rdata = st_ff.rdata;
   assign acq_start_pulse = st_ff.acq_pulse;
   assign pins = st_ff.pins;

   always_comb begin
      logic gen_en, run_en, run_active, chk_en, chk_err, clr_fall;
      logic [1:0] gen_mode, chk_mode;
      logic [10:0] run_bits;
      logic fb;
      gen_en = st_ff.gen_ctrl[BIT_ENABLE];
      gen_mode = st_ff.gen_ctrl[1:0];
      run_en = st_ff.gen_ctrl[BIT_RUN_EN];
      run_bits = 11'(st_ff.run_len) << RUN_UNIT_SHIFT;
      run_active = run_en && (st_ff.run_len != 8'h00);
      chk_en = st_ff.chk_ctrl[BIT_ENABLE];
      chk_mode = st_ff.chk_ctrl[1:0];
      fb = prbs_feedback(gen_mode, st_ff.lfsr);
      clr_fall = 1'b0;
      nxt_st = st_ff;
      nxt_st.acq_pulse = 1'b0;

      nxt_st.rx_meta = rx_data_in;
      nxt_st.rx_sync = st_ff.rx_meta;
      nxt_st.rate_meta = rate_in;
      nxt_st.rate_sync = st_ff.rate_meta;

      // Register writes; read-only offsets ignore writes
      if (reg_req.we) begin
         case (reg_req.addr)
            ADDR_CTRL_B: begin
               nxt_st.ctrl_b = reg_req.wdata;
               nxt_st.acq_pulse = write_falls(st_ff.ctrl_b, reg_req.wdata, BIT_ACQ_START);
            end
            ADDR_OUT_BUF: nxt_st.out_buf = reg_req.wdata;
            ADDR_GEN_CTRL: nxt_st.gen_ctrl = reg_req.wdata;
            ADDR_RUN_LEN: nxt_st.run_len = reg_req.wdata;
            ADDR_PAT_B3: nxt_st.user_pattern[31:24] = reg_req.wdata;
            ADDR_PAT_B2: nxt_st.user_pattern[23:16] = reg_req.wdata;
            ADDR_PAT_B1: nxt_st.user_pattern[15:8] = reg_req.wdata;
            ADDR_PAT_B0: nxt_st.user_pattern[7:0] = reg_req.wdata;
            ADDR_CHK_CTRL: begin
               nxt_st.chk_ctrl = reg_req.wdata;
               clr_fall = write_falls(st_ff.chk_ctrl, reg_req.wdata, BIT_CHK_CLEAR);
            end
            default: ;
         endcase
      end
      nxt_st.rdata = read_map(st_ff, reg_req.addr);

      // Bit source: generator when enabled, else the received stream; stalls on a full FIFO
      src_bit = st_ff.rx_sync;
      if (gen_en) begin
         if (run_active && st_ff.in_run) begin
            src_bit = st_ff.gen_ctrl[BIT_RUN_VAL];
         end else if (gen_mode == MODE_USER) begin
            src_bit = st_ff.user_pattern[5'd31 - st_ff.pat_idx];
         end else begin
            src_bit = fb;
         end
      end
      if (gen_en && fifo_in_ready) begin
         if (!(run_active && st_ff.in_run)) begin
            if (gen_mode == MODE_USER) begin
               nxt_st.pat_idx = st_ff.pat_idx + 5'd1;
            end else begin
               nxt_st.lfsr = {st_ff.lfsr[29:0], fb};
               if (prbs_stuck(gen_mode, st_ff.lfsr)) begin
                  nxt_st.lfsr = LFSR_SEED;
               end
            end
         end
         if (run_active) begin
            if (st_ff.seg_cnt >= run_bits - 11'd1) begin
               nxt_st.seg_cnt = 11'd0;
               nxt_st.in_run = ~st_ff.in_run;
            end else begin
               nxt_st.seg_cnt = st_ff.seg_cnt + 11'd1;
            end
         end else begin
            nxt_st.seg_cnt = 11'd0;
            nxt_st.in_run = 1'b0;
         end
      end

      // Checker predicts each received bit from the last ones received
      nxt_st.chk_hist = {st_ff.chk_hist[29:0], st_ff.rx_sync};
      chk_err = chk_en && (chk_mode != MODE_USER) &&
                (st_ff.rx_sync != prbs_feedback(chk_mode, st_ff.chk_hist));
      if (clr_fall) begin
         nxt_st.pattern_error_flag = 1'b0;
         nxt_st.pattern_error_tally = 8'h00;
      end
      // Disabled checker counts no errors, but a falling clear bit still resets flag and tally; an error beats a clear
      if (chk_err) begin
         nxt_st.pattern_error_flag = 1'b1;
         if (clr_fall) begin
            nxt_st.pattern_error_tally = 8'h01;
         end else if (st_ff.pattern_error_tally != ERR_MAX) begin
            nxt_st.pattern_error_tally = st_ff.pattern_error_tally + 8'h01;
         end
      end

      // One-shot capture, rearmed once mode 3 or enable is left
      case (st_ff.cap_state)
         CAP_IDLE: begin
            if (chk_en && chk_mode == MODE_USER) begin
               nxt_st.cap_state = CAP_RUN;
               nxt_st.cap_cnt = 5'd0;
            end
         end
         CAP_RUN: begin
            nxt_st.captured_sample = {st_ff.captured_sample[14:0], st_ff.rx_sync};
            nxt_st.cap_cnt = st_ff.cap_cnt + 5'd1;
            if (st_ff.cap_cnt == CAP_LAST) begin
               nxt_st.cap_state = CAP_DONE;
            end
         end
         CAP_DONE: begin
            if (!(chk_en && chk_mode == MODE_USER)) begin
               nxt_st.cap_state = CAP_IDLE;
            end
         end
         default: nxt_st.cap_state = CAP_IDLE;
      endcase

      // Output stage: one bit per pop, clock toggles per bit
      if (fifo_pop) begin
         nxt_st.pins.data_out = fifo_out_bit;
         nxt_st.pins.clk_out = ~st_ff.pins.clk_out;
      end
      nxt_st.pins.data_oe = ~st_ff.out_buf[BIT_DAT_OFF];
      nxt_st.pins.clk_oe = ~st_ff.out_buf[BIT_DAT_OFF] & ~st_ff.out_buf[BIT_CLK_OFF];
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_ff <= '0;
         st_ff.ctrl_b <= REG_RESET;
         st_ff.out_buf <= REG_RESET;
         st_ff.gen_ctrl <= REG_RESET;
         st_ff.run_len <= REG_RESET;
         st_ff.user_pattern <= PAT_RESET;
         st_ff.chk_ctrl <= REG_RESET;
         st_ff.lfsr <= LFSR_SEED;
         st_ff.cap_state <= CAP_IDLE;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end
endmodule

`default_nettype wire

/* hdl/pgc_pkg.sv */
// Shared constants and carrier types for the pattern generator, checker and output control
`default_nettype none
package pgc_pkg;
   localparam logic [7:0] ADDR_RATE_FINE = 8'h04;
   localparam logic [7:0] ADDR_RATE_CORE = 8'h05;
   localparam logic [7:0] ADDR_CTRL_B = 8'h09;
   localparam logic [7:0] ADDR_OUT_BUF = 8'h1e;
   localparam logic [7:0] ADDR_GEN_CTRL = 8'h39;
   localparam logic [7:0] ADDR_RUN_LEN = 8'h3a;
   localparam logic [7:0] ADDR_PAT_B3 = 8'h3b;
   localparam logic [7:0] ADDR_PAT_B2 = 8'h3c;
   localparam logic [7:0] ADDR_PAT_B1 = 8'h3d;
   localparam logic [7:0] ADDR_PAT_B0 = 8'h3e;
   localparam logic [7:0] ADDR_CHK_CTRL = 8'h3f;
   localparam logic [7:0] ADDR_ERR_CNT = 8'h40;
   localparam logic [7:0] ADDR_ERR_STAT = 8'h41;
   localparam logic [7:0] ADDR_CAP_HI = 8'h42;
   localparam logic [7:0] ADDR_CAP_LO = 8'h43;

   localparam int BIT_ACQ_START = 6;
   localparam int BIT_CLK_OFF = 3;
   localparam int BIT_DAT_OFF = 4;
   localparam int BIT_ENABLE = 2;
   localparam int BIT_CHK_CLEAR = 3;
   localparam int BIT_RUN_EN = 4;
   localparam int BIT_RUN_VAL = 5;
   localparam int BIT_FULL_RATE = 6;

   localparam logic [1:0] MODE_PRBS7 = 2'h0;
   localparam logic [1:0] MODE_PRBS15 = 2'h1;
   localparam logic [1:0] MODE_PRBS31 = 2'h2;
   localparam logic [1:0] MODE_USER = 2'h3;

   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [31:0] PAT_RESET = 32'h00000000;
   localparam logic [30:0] LFSR_SEED = 31'h7fffffff;
   localparam logic [7:0] ERR_MAX = 8'hff;
   localparam logic [4:0] CAP_LAST = 5'h0f;
   localparam int RUN_UNIT_SHIFT = 3;
   localparam int FIFO_WIDTH = 1;
   localparam int FIFO_DEPTH = 8;

   typedef struct packed {
      logic we;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pgc_reg_req_type;

   typedef struct packed {
      logic [9:0] osc_code;
      logic full_rate;
      logic [3:0] divide_rate;
   } pgc_rate_type;

   typedef struct packed {
      logic data_out;
      logic data_oe;
      logic clk_out;
      logic clk_oe;
   } pgc_pins_type;
endpackage
`default_nettype wire

/* tb/pgc_top_assertions.sv */
// Port-level checker for the pattern block
`timescale 1ns/1ps
`default_nettype none
module pgc_top_assertions (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire pgc_pkg::pgc_reg_req_type reg_req,
   input wire logic [7:0] reg_rdata,
   input wire pgc_pkg::pgc_rate_type rate_in,
   input wire logic out_ready,
   input wire logic acq_start_pulse,
   input wire pgc_pkg::pgc_pins_type pins
);
   import pgc_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_acq_one;
      acq_start_pulse |=> !acq_start_pulse;
   endproperty
   a_acq_one: assert property (p_acq_one)
      else $error("restart pulse too long");
   property p_acq_cause;
      acq_start_pulse |-> $past(reg_req.we && reg_req.addr == ADDR_CTRL_B)
         || $past(reg_req.we && reg_req.addr == ADDR_CTRL_B, 2);
   endproperty
   a_acq_cause: assert property (p_acq_cause)
      else $error("restart pulse without control write");
   property p_rate_core;
      (ce && $stable(rate_in))[*4] ##0 reg_req.addr == ADDR_RATE_CORE |=> reg_rdata ==
         {1'b0, $past(rate_in.full_rate), $past(rate_in.divide_rate), $past(rate_in.osc_code[9:8])};
   endproperty
   a_rate_core: assert property (p_rate_core)
      else $error("core readback layout wrong");
   property p_pat_rb;
      ce && reg_req.we && reg_req.addr == ADDR_PAT_B3 ##1 ce && !reg_req.we
         && reg_req.addr == ADDR_PAT_B3 |=> reg_rdata == $past(reg_req.wdata, 2);
   endproperty
   a_pat_rb: assert property (p_pat_rb)
      else $error("pattern byte readback wrong");
   property p_clk_off;
      ce && reg_req.we && reg_req.addr == ADDR_OUT_BUF && reg_req.wdata[4:3] == 2'b01
         |-> ##[1:3] (!pins.clk_oe && pins.data_oe);
   endproperty
   a_clk_off: assert property (p_clk_off)
      else $error("clock off did not act alone");
   property p_dat_off;
      ce && reg_req.we && reg_req.addr == ADDR_OUT_BUF && reg_req.wdata[4]
         |-> ##[1:3] (!pins.clk_oe && !pins.data_oe);
   endproperty
   a_dat_off: assert property (p_dat_off)
      else $error("data off left a buffer on");
   property p_clk_pace;
      $changed(pins.clk_out) |-> $past(ce && out_ready);
   endproperty
   a_clk_pace: assert property (p_clk_pace)
      else $error("clock moved without a bit taken");
   property p_clk_with_data;
      $changed(pins.data_out) |-> $changed(pins.clk_out);
   endproperty
   a_clk_with_data: assert property (p_clk_with_data)
      else $error("data moved without a clock edge");
endmodule
bind pgc_top pgc_top_assertions u_chk (.clk(clk), .rst(rst), .ce(ce), .reg_req(reg_req),
   .reg_rdata(reg_rdata), .rate_in(rate_in), .out_ready(out_ready),
   .acq_start_pulse(acq_start_pulse), .pins(pins));
`default_nettype wire

/* tb/pgc_link_partner.sv */
// Far side of the link: bit source for the checker, bit sink for the outputs
`timescale 1ns/1ps
`default_nettype none
module pgc_link_partner (
   input wire logic clk,
   input wire logic [1:0] src_mode,
   input wire logic src_flip,
   input wire logic src_level,
   input wire logic slow,
   input wire logic stall,
   input wire logic clk_out,
   input wire logic data_out,
   output logic rx_bit,
   output logic ready
);
   logic [30:0] lfsr = 31'h7fffffff;
   logic [1:0] pace = 2'h0;
   logic fb;
   logic last_clk = 1'b0;
   logic got[$];
   initial begin
      rx_bit = 1'b0;
      ready = 1'b0;
   end
   always_comb begin
      case (src_mode)
         2'h0: fb = lfsr[6] ^ lfsr[5];
         2'h1: fb = lfsr[14] ^ lfsr[13];
         2'h2: fb = lfsr[30] ^ lfsr[27];
         default: fb = src_level;
      endcase
   end
   // Slow mode takes one bit in four to fill the buffer
   always @(posedge clk) begin
      lfsr <= {lfsr[29:0], fb};
      rx_bit <= fb ^ src_flip;
      pace <= pace + 2'h1;
      ready <= !stall && (!slow || pace == 2'h0);
      if (clk_out !== last_clk)
         got.push_back(data_out);
      last_clk <= clk_out;
   end
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Register-driven bench for the pattern block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import pgc_pkg::*;
   logic clk = 1'b0, rst = 1'b1, ce = 1'b1, out_ready, rx_data_in, acq_start_pulse;
   pgc_reg_req_type reg_req = '0;
   pgc_rate_type rate_in = {10'h311, 1'b1, 4'ha};
   pgc_pins_type pins;
   logic [7:0] reg_rdata, v;
   logic [1:0] src_mode = 2'h0;
   logic src_flip = 1'b0, src_level = 1'b1, slow = 1'b0, stall = 1'b0;
   int mismatches = 0, comparisons = 0, n, pulses = 0;
   logic [7:0] ra[12] = '{8'h09, 8'h1e, 8'h39, 8'h3a, 8'h3b, 8'h3c, 8'h3d, 8'h3e, 8'h3f,
      8'h40, 8'h41, 8'h80};
   logic [7:0] ob[4] = '{8'h08, 8'h10, 8'h18, 8'h00};
   logic [1:0] oe[4] = '{2'b01, 2'b00, 2'b00, 2'b11};
   int ta[3] = '{7, 15, 31};
   int tb[3] = '{6, 14, 28};
   initial forever #10 clk = ~clk;
   pgc_top u_dut (.clk(clk), .rst(rst), .ce(ce), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .rx_data_in(rx_data_in), .rate_in(rate_in), .out_ready(out_ready),
      .acq_start_pulse(acq_start_pulse), .pins(pins));
   pgc_link_partner u_partner (.clk(clk), .src_mode(src_mode), .src_flip(src_flip),
      .src_level(src_level), .slow(slow), .stall(stall), .clk_out(pins.clk_out),
      .data_out(pins.data_out), .rx_bit(rx_data_in), .ready(out_ready));
   always @(posedge clk) if (acq_start_pulse === 1'b1) pulses++;
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_req = '{we: 1'b1, addr: a, wdata: d};
      @(negedge clk);
      reg_req.we = 1'b0;
      @(negedge clk);
   endtask
   task automatic rd(input logic [7:0] a);
      reg_req.addr = a;
      @(negedge clk);
      v = reg_rdata;
   endtask
   task automatic flip;
      src_flip = 1'b1;
      @(negedge clk);
      src_flip = 1'b0;
      repeat (40) @(negedge clk);
   endtask
   task automatic longest(input logic b);
      int r;
      n = 0;
      r = 0;
      foreach (u_partner.got[i]) begin
         r = (u_partner.got[i] === b) ? r + 1 : 0;
         if (r > n) n = r;
      end
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (10) @(negedge clk);
      rst = 1'b0;
      foreach (ra[i]) begin
         rd(ra[i]);
         chk("reset value", 0, v);
      end
      for (int i = 0; i < 9; i++) begin
         wr(ra[i], 8'h5a);
         rd(ra[i]);
         chk("readback", 8'h5a, v);
         wr(ra[i], 8'h00);
      end
      wr(ADDR_RATE_CORE, 8'hff);
      rd(ADDR_RATE_CORE);
      chk("rate core", 8'h6b, v);
      rd(ADDR_RATE_FINE);
      chk("rate fine", 8'h11, v);
      pulses = 0;
      wr(ADDR_CTRL_B, 8'h44);
      ce = 1'b0;
      wr(ADDR_CTRL_B, 8'h04);
      ce = 1'b1;
      rd(ADDR_CTRL_B);
      chk("frozen control", 8'h44, v);
      wr(ADDR_CTRL_B, 8'h04);
      rd(ADDR_CTRL_B);
      chk("restart pulses", 1, pulses);
      chk("control kept", 8'h04, v);
      foreach (ob[i]) begin
         wr(ADDR_OUT_BUF, ob[i]);
         repeat (3) @(negedge clk);
         chk("buffer enables", oe[i], {pins.clk_oe, pins.data_oe});
      end
      for (int m = 0; m < 3; m++) begin
         wr(ADDR_GEN_CTRL, {6'h01, m[1:0]});
         u_partner.got.delete();
         stall = 1'b1;
         repeat (20) @(negedge clk);
         stall = 1'b0;
         slow = (m == 1);
         repeat (300) @(negedge clk);
         n = 0;
         for (int i = 48; i < u_partner.got.size(); i++)
            if (u_partner.got[i] !== (u_partner.got[i-ta[m]] ^ u_partner.got[i-tb[m]])) n++;
         chk("sequence breaks", 0, n);
         chk("bits taken", 1, u_partner.got.size() > 64);
      end
      slow = 1'b0;
      wr(ADDR_PAT_B3, 8'hde);
      rd(ADDR_PAT_B3);
      wr(ADDR_PAT_B2, 8'had);
      wr(ADDR_PAT_B1, 8'hbe);
      wr(ADDR_PAT_B0, 8'hef);
      wr(ADDR_GEN_CTRL, 8'h07);
      u_partner.got.delete();
      repeat (200) @(negedge clk);
      n = 0;
      for (int i = 16; i < u_partner.got.size() - 32; i++)
         if (u_partner.got[i] !== u_partner.got[i+32]) n++;
      chk("pattern period", 0, n);
      n = 0;
      for (int i = 16; i < 48; i++) n += u_partner.got[i];
      chk("pattern ones", $countones(32'hdeadbeef), n);
      wr(ADDR_RUN_LEN, 8'h02);
      for (int b = 0; b < 2; b++) begin
         wr(ADDR_GEN_CTRL, {2'b00, b[0], 5'h14});
         u_partner.got.delete();
         repeat (200) @(negedge clk);
         longest(b[0]);
         chk("longest run ok", 1, n >= 16 && n <= 30);
      end
      wr(ADDR_GEN_CTRL, 8'h00);
      for (int m = 0; m < 3; m++) begin
         src_mode = m[1:0];
         wr(ADDR_CHK_CTRL, {6'h01, m[1:0]});
         repeat (60) @(negedge clk);
         wr(ADDR_CHK_CTRL, {6'h03, m[1:0]});
         wr(ADDR_CHK_CTRL, {6'h01, m[1:0]});
         flip();
         rd(ADDR_ERR_CNT);
         chk("error tally", 3, v);
         rd(ADDR_ERR_STAT);
         chk("error flag", 1, v[0]);
      end
      wr(ADDR_CHK_CTRL, 8'h02);
      flip();
      rd(ADDR_ERR_CNT);
      chk("frozen tally", 3, v);
      wr(ADDR_CHK_CTRL, 8'h06);
      repeat (90) flip();
      rd(ADDR_ERR_CNT);
      chk("saturated tally", ERR_MAX, v);
      wr(ADDR_CHK_CTRL, 8'h0e);
      wr(ADDR_CHK_CTRL, 8'h06);
      rd(ADDR_ERR_CNT);
      chk("cleared tally", 0, v);
      rd(ADDR_ERR_STAT);
      chk("cleared flag", 0, v[0]);
      src_mode = MODE_USER;
      repeat (10) @(negedge clk);
      wr(ADDR_CHK_CTRL, 8'h07);
      src_level = 1'b0;
      repeat (30) @(negedge clk);
      src_level = 1'b1;
      repeat (30) @(negedge clk);
      rd(ADDR_CAP_HI);
      chk("capture high", 8'he0, v);
      rd(ADDR_CAP_LO);
      chk("capture low", 8'h00, v);
      results();
   end
endmodule
`default_nettype wire
